// [verilog/rgp_regs.svh]
// register offsets, field positions, reset values and timing counts of the port
`ifndef RGP_REGS_SVH
`define RGP_REGS_SVH
// register offsets on the plain software port
`define RGP_CTRL0_ADDR    8'h00
`define RGP_CTRL1_ADDR    8'h01
`define RGP_CTRL3_ADDR    8'h03
// reset values, strapped bits are overwritten once the straps are caught
`define RGP_CTRL0_RST     8'h50
`define RGP_CTRL1_RST     8'h08
// writable bits of each control register
`define RGP_CTRL0_MASK    8'h50
`define RGP_CTRL1_MASK    8'h5C
// control 0 fields
`define RGP_C0_SPD100_BIT 4
`define RGP_C0_DUPLEX_BIT 6
// control 1 fields
`define RGP_C1_GIG_BIT    6
`define RGP_C1_ING_BIT    4
`define RGP_C1_EGR_BIT    3
`define RGP_C1_IBS_BIT    2
// control 3 fields (read only)
`define RGP_C3_LINK_BIT   0
`define RGP_C3_SPD_LSB    1
`define RGP_C3_DUP_BIT    3
`define RGP_C3_MODE_BIT   7
// strap code that selects this interface mode
`define RGP_MODE_STRAP    2'b11
// cycles after reset release at which the synchronised straps are caught
`define RGP_STRAP_WAIT    2'h2
// link clock half periods in system cycles, ratio 1:5:50 as 125/25/2.5 MHz
`define RGP_HALF_1000     8'h02
`define RGP_HALF_100      8'h0A
`define RGP_HALF_10       8'h64
// internal clock delay, least time rounded up to whole cycles
`define RGP_DELAY_PS      1500
`define RGP_SYS_PERIOD_PS 40000
`define RGP_DELAY_CYC     ((`RGP_DELAY_PS + `RGP_SYS_PERIOD_PS - 1) / `RGP_SYS_PERIOD_PS)
`endif

// [verilog/rgp_pkg.sv]
// types and helper functions shared by both ends of the port
`include "rgp_regs.svh"
package rgp_pkg;
  // link speed code, as carried in the in-band status nibble
  typedef enum logic [1:0] {
    RGP_SPD_10   = 2'b00,
    RGP_SPD_100  = 2'b01,
    RGP_SPD_1000 = 2'b10
  } rgp_speed_t;

  // half period of the link clock for a speed
  function automatic logic [7:0] rgp_half(input rgp_speed_t s);
    logic [7:0] h;
    h = `RGP_HALF_10;
    if (s == RGP_SPD_1000)
    begin
      h = `RGP_HALF_1000;
    end
    else if (s == RGP_SPD_100)
    begin
      h = `RGP_HALF_100;
    end
    return h;
  endfunction

  // raw two-bit speed field to speed, reserved code falls back to 10
  function automatic rgp_speed_t rgp_spd(input logic [1:0] b);
    rgp_speed_t s;
    s = RGP_SPD_10;
    if (b == 2'b10)
    begin
      s = RGP_SPD_1000;
    end
    else if (b == 2'b01)
    begin
      s = RGP_SPD_100;
    end
    return s;
  endfunction
endpackage

// [verilog/rgp_if.sv]
// link wires between the device end and the partner end
`timescale 1ns/10ps
interface rgp_if;
  logic       tx_clk;  // transmit clock, made by partner
  logic       tx_ctl;  // transmit control
  logic [3:0] txd;     // transmit nibble
  logic       rx_clk;  // receive clock, made by device
  logic       rx_ctl;  // receive control
  logic [3:0] rxd;     // receive nibble

  modport device (
    input  tx_clk,
    input  tx_ctl,
    input  txd,
    output rx_clk,
    output rx_ctl,
    output rxd
  );

  modport partner (
    output tx_clk,
    output tx_ctl,
    output txd,
    input  rx_clk,
    input  rx_ctl,
    input  rxd
  );
endinterface

// [verilog/rgp_device.sv]
// device end of the port: lane sender, lane receiver and the device top
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "rgp_regs.svh"

// one outgoing lane: makes the link clock and launches nibbles on its edges
module rgp_lane_tx
  import rgp_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // synchronous reset, high
  input  wire rgp_speed_t speed,    // lane speed
  input  wire logic       dly_en,   // delay the outgoing clock
  input  wire logic [7:0] byte_in,  // byte to send
  input  wire logic       valid_in, // byte is valid
  input  wire logic       err_in,   // byte carries an error
  input  wire logic [3:0] idle_in,  // nibble sent between frames
  output logic            ready,    // byte taken this cycle
  output logic            lclk,     // link clock
  output logic            lctl,     // link control
  output logic [3:0]      ld        // link nibble
);
  logic [7:0]                cnt_q;  // half period counter
  logic                      clk_q;  // undelayed link clock
  logic                      hi_q;   // slow speeds: high nibble next
  logic [7:0]                byte_q; // byte in flight
  logic                      val_q;  // byte in flight is valid
  logic                      err_q;  // byte in flight has error
  logic [3:0]                d_q;    // nibble on the pins
  logic                      ctl_q;  // control on the pins
  logic [`RGP_DELAY_CYC-1:0] line_q; // clock delay line
  logic                      gig;
  logic                      tick;
  logic                      rise;
  logic                      fall;
  logic                      take;

  assign gig  = (speed == RGP_SPD_1000);
  // >= so that a speed change to a shorter period never overruns
  assign tick = (cnt_q >= (rgp_half(speed) - 8'h01));
  assign rise = tick & ~clk_q;
  assign fall = tick & clk_q;
  // a new byte each period at gigabit, every second period otherwise
  assign take  = rise & (gig | ~hi_q);
  assign ready = take;

  // half period counter
  always_ff @(posedge clk)
  begin
    if (rst || tick)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // link clock divider, rate set by speed
  always_ff @(posedge clk)
  begin
    if (rst)
      clk_q <= 1'b0;
    else if (tick)
      clk_q <= ~clk_q;
  end

  // byte held while its nibbles go out
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      byte_q <= 8'h00;
      val_q  <= 1'b0;
      err_q  <= 1'b0;
    end
    else if (take)
    begin
      byte_q <= byte_in;
      val_q  <= valid_in;
      err_q  <= valid_in & err_in;
    end
  end

  // nibble phase at slow speeds
  always_ff @(posedge clk)
  begin
    if (rst || gig)
      hi_q <= 1'b0;
    else if (rise)
      hi_q <= ~hi_q;
  end

  // pin launch on each clock edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d_q   <= 4'h0;
      ctl_q <= 1'b0;
    end
    else if (take)
    begin
      // low nibble and valid at the rising edge
      d_q   <= valid_in ? byte_in[3:0] : idle_in;
      ctl_q <= valid_in;
    end
    else if (rise)
    begin
      // slow speeds, second period carries the high nibble
      d_q   <= val_q ? byte_q[7:4] : idle_in;
      ctl_q <= val_q;
    end
    else if (fall)
    begin
      // gigabit: high nibble; slow: nibble repeated
      if (gig)
        d_q <= val_q ? byte_q[7:4] : idle_in;
      ctl_q <= val_q ^ err_q;
    end
  end

  // internal delay line for the outgoing clock
  always_ff @(posedge clk)
  begin
    if (rst)
      line_q <= '0;
    else
    begin
      line_q[0] <= clk_q;
      for (int i = 1; i < `RGP_DELAY_CYC; i++)
        line_q[i] <= line_q[i-1];
    end
  end

  assign lclk = dly_en ? line_q[`RGP_DELAY_CYC-1] : clk_q;
  assign lctl = ctl_q;
  assign ld   = d_q;
endmodule

// one incoming lane: synchronises the pins and rebuilds bytes at clock edges
module rgp_lane_rx
  import rgp_pkg::*;
(
  input  wire logic       clk,       // system clock
  input  wire logic       rst,       // synchronous reset, high
  input  wire rgp_speed_t speed,     // lane speed
  input  wire logic       dly_en,    // delay the incoming clock
  input  wire logic       lclk,      // link clock pin
  input  wire logic       lctl,      // link control pin
  input  wire logic [3:0] ld,        // link nibble pins
  output logic [7:0]      byte_out,  // received byte
  output logic            valid_out, // one-cycle byte pulse
  output logic            err_out,   // error beside the byte
  output logic            active_out,// frame in progress
  output logic [3:0]      idle_out   // last nibble between frames
);
  logic [5:0]                s1_q;   // first sync stage
  logic [5:0]                s2_q;   // second sync stage
  logic [`RGP_DELAY_CYC-1:0] cl_q;   // incoming clock delay line
  logic                      prev_q; // clock seen last cycle
  logic [3:0]                lo_q;   // low nibble
  logic [3:0]                hi_q;   // high nibble at slow speeds
  logic                      rctl_q; // control at last rising edge
  logic                      half_q; // low nibble held
  logic                      pend_q; // slow byte complete
  logic                      eacc_q; // error of first nibble
  logic                      gig;
  logic                      ck;
  logic                      c;
  logic [3:0]                d;
  logic                      rise;
  logic                      fall;
  logic                      emit;

  assign gig  = (speed == RGP_SPD_1000);
  assign ck   = dly_en ? cl_q[`RGP_DELAY_CYC-1] : s2_q[5];
  assign c    = s2_q[4];
  assign d    = s2_q[3:0];
  assign rise = ck & ~prev_q;
  assign fall = ~ck & prev_q;
  assign emit = fall & ((gig & rctl_q) | pend_q);

  // two-stage synchroniser on all lane pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end
    else
    begin
      s1_q <= {lclk, lctl, ld};
      s2_q <= s1_q;
    end
  end

  // clock delay line and edge detector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cl_q   <= '0;
      prev_q <= 1'b0;
    end
    else
    begin
      cl_q[0] <= s2_q[5];
      for (int i = 1; i < `RGP_DELAY_CYC; i++)
        cl_q[i] <= cl_q[i-1];
      prev_q <= ck;
    end
  end

  // rising edge: valid and low nibble; falling edge: error and output
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lo_q <= 4'h0;
      hi_q <= 4'h0;
      rctl_q <= 1'b0;
      half_q <= 1'b0;
      pend_q <= 1'b0;
      eacc_q <= 1'b0;
      idle_out <= 4'h0;
    end
    else if (rise)
    begin
      rctl_q <= c;
      if (!c)
      begin
        // between frames the nibble is in-band status
        idle_out <= d;
        half_q   <= 1'b0;
        pend_q   <= 1'b0;
        eacc_q   <= 1'b0;
      end
      else if (gig)
        lo_q <= d;
      else if (half_q)
      begin
        hi_q   <= d;
        half_q <= 1'b0;
        pend_q <= 1'b1;
      end
      else
      begin
        lo_q   <= d;
        half_q <= 1'b1;
      end
    end
    else if (fall)
    begin
      if (pend_q)
      begin
        pend_q <= 1'b0;
        eacc_q <= 1'b0;
      end
      else if (half_q)
        eacc_q <= rctl_q ^ c;
    end
  end

  // byte output registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      byte_out  <= 8'h00;
      valid_out <= 1'b0;
      err_out   <= 1'b0;
    end
    else
    begin
      valid_out <= emit;
      if (emit)
      begin
        byte_out <= {gig ? d : hi_q, lo_q};
        // error is valid xor falling-edge control, or at slow speeds the first-nibble error in eacc_q
        err_out  <= (rctl_q ^ c) | (~gig & eacc_q);
      end
    end
  end

  assign active_out = rctl_q;
endmodule

// device end: straps, control registers, in-band status and both lanes
module rgp_device
  import rgp_pkg::*;
(
  input  wire logic       SYS_CLK,                 // system clock
  input  wire logic       RESET,                   // synchronous reset, high
  input  wire logic [7:0] REG_ADDR,                // register address
  input  wire logic [7:0] REG_WDATA,               // write data
  input  wire logic       REG_WR,                  // write strobe
  input  wire logic       REG_RD,                  // read strobe
  output logic [7:0]      REG_RDATA,               // read data, cycle after strobe
  input  wire logic [1:0] MODE_STRAP,              // upper receive data straps
  input  wire logic       SPEED_STRAP,             // high: 1000, low: 100
  input  wire logic       INBAND_STATUS_STRAP_PIN, // in-band status enable strap
  input  wire logic [7:0] SEND_BYTE,               // byte toward partner
  input  wire logic       SEND_VALID,              // byte valid
  input  wire logic       SEND_ERROR,              // byte error
  output logic            SEND_READY,              // byte taken
  output logic [7:0]      RECV_BYTE,               // byte from partner
  output logic            RECV_VALID,              // byte pulse
  output logic            RECV_ERROR,              // error beside byte
  output logic            RECV_ACTIVE,             // frame in progress
  output logic            PORT_ENABLED,            // interface mode selected
  output logic            LINK_UP,                 // effective link
  output logic [1:0]      SPEED,                   // effective speed code
  output logic            FULL_DUPLEX,             // effective duplex
  rgp_if.device           link                     // link wires
);
  logic [3:0] st1_q;   // strap sync, first stage
  logic [3:0] st2_q;   // strap sync, second stage
  logic [1:0] cap_q;   // cycles since reset release
  logic       mode_q;  // interface mode caught from straps
  logic [7:0] ctrl0_q; // port_interface_control_0
  logic [7:0] ctrl1_q; // port_interface_control_1
  logic [7:0] ctrl3;   // port_interface_control_3, read only
  logic [3:0] inband_status;     // in-band status nibble
  logic       capture;
  logic       ibs_en;
  logic       lane_rst;
  rgp_speed_t reg_spd;
  rgp_speed_t spd;

  assign capture = (cap_q == `RGP_STRAP_WAIT);

  // straps are pins: two flip-flops before use
  always_ff @(posedge SYS_CLK)
  begin
    st1_q <= {MODE_STRAP, SPEED_STRAP, INBAND_STATUS_STRAP_PIN};
    st2_q <= st1_q;
  end

  // counts one past the strap capture point and stops
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      cap_q <= 2'h0;
    else if (cap_q != 2'h3)
      cap_q <= cap_q + 2'h1;
  end

  // interface mode caught once after reset
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      mode_q <= 1'b0;
    else if (capture)
      mode_q <= (st2_q[3:2] == `RGP_MODE_STRAP);
  end

  // control 0: slow speed and duplex
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      ctrl0_q <= `RGP_CTRL0_RST;
    else if (REG_WR && REG_ADDR == `RGP_CTRL0_ADDR)
      ctrl0_q <= REG_WDATA & `RGP_CTRL0_MASK;
  end

  // control 1: gigabit, delays, in-band enable; straps load it once
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      ctrl1_q <= `RGP_CTRL1_RST;
    else if (REG_WR && REG_ADDR == `RGP_CTRL1_ADDR)
      ctrl1_q <= REG_WDATA & `RGP_CTRL1_MASK;
    else if (capture)
    begin
      ctrl1_q[`RGP_C1_GIG_BIT] <= st2_q[1];
      ctrl1_q[`RGP_C1_IBS_BIT] <= st2_q[0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || !REG_RD)
      REG_RDATA <= 8'h00;
    else
    begin
      unique case (REG_ADDR)
        `RGP_CTRL0_ADDR: REG_RDATA <= ctrl0_q;
        `RGP_CTRL1_ADDR: REG_RDATA <= ctrl1_q;
        `RGP_CTRL3_ADDR: REG_RDATA <= ctrl3;
        default:         REG_RDATA <= 8'h00;
      endcase
    end
  end

  // link, speed and duplex: from in-band status or from the registers
  assign ctrl3 = {mode_q, 3'b000, inband_status};
  assign ibs_en  = ctrl1_q[`RGP_C1_IBS_BIT];
  assign reg_spd = ctrl1_q[`RGP_C1_GIG_BIT] ? RGP_SPD_1000 :
                   (ctrl0_q[`RGP_C0_SPD100_BIT] ? RGP_SPD_100 : RGP_SPD_10);
  // with no in-band status the partner is trusted to sit at reg speed
  assign spd = ibs_en ? rgp_spd(inband_status[`RGP_C3_SPD_LSB +: 2]) : reg_spd;
  assign LINK_UP      = ibs_en ? inband_status[`RGP_C3_LINK_BIT] : mode_q;
  assign FULL_DUPLEX  = ibs_en ? inband_status[`RGP_C3_DUP_BIT] : ctrl0_q[`RGP_C0_DUPLEX_BIT];
  assign SPEED        = spd;
  assign PORT_ENABLED = mode_q;
  // lanes idle while the mode is not selected
  assign lane_rst = RESET | ~mode_q;

  // receive lane toward the partner, egress delay on its clock
  rgp_lane_tx u_send (
    .clk      (SYS_CLK),
    .rst      (lane_rst),
    .speed    (spd),
    .dly_en   (ctrl1_q[`RGP_C1_EGR_BIT]),
    .byte_in  (SEND_BYTE),
    .valid_in (SEND_VALID & LINK_UP),
    .err_in   (SEND_ERROR),
    .idle_in  (4'h0),
    .ready    (SEND_READY),
    .lclk     (link.rx_clk),
    .lctl     (link.rx_ctl),
    .ld       (link.rxd)
  );

  // transmit lane from the partner, ingress delay on its clock
  rgp_lane_rx u_recv (
    .clk        (SYS_CLK),
    .rst        (lane_rst),
    .speed      (spd),
    .dly_en     (ctrl1_q[`RGP_C1_ING_BIT]),
    .lclk       (link.tx_clk),
    .lctl       (link.tx_ctl),
    .ld         (link.txd),
    .byte_out   (RECV_BYTE),
    .valid_out  (RECV_VALID),
    .err_out    (RECV_ERROR),
    .active_out (RECV_ACTIVE),
    .idle_out   (inband_status)
  );
endmodule

// [verilog/rgp_partner.sv]
// partner end of the port: makes the transmit clock and sends in-band status
`timescale 1ns/10ps
`include "rgp_regs.svh"
module rgp_partner
  import rgp_pkg::*;
(
  input  wire logic       SYS_CLK,     // system clock
  input  wire logic       RESET,       // synchronous reset, high
  input  wire logic [1:0] SPEED,       // link speed code
  input  wire logic       IBS_LINK,    // in-band link up
  input  wire logic       IBS_DUPLEX,  // in-band full duplex
  input  wire logic [7:0] SEND_BYTE,   // byte toward device
  input  wire logic       SEND_VALID,  // byte valid
  input  wire logic       SEND_ERROR,  // byte error
  output logic            SEND_READY,  // byte taken
  output logic [7:0]      RECV_BYTE,   // byte from device
  output logic            RECV_VALID,  // byte pulse
  output logic            RECV_ERROR,  // error beside byte
  output logic            RECV_ACTIVE, // frame in progress
  rgp_if.partner          link         // link wires
);
  rgp_speed_t spd;      // decoded speed
  logic [3:0] status;   // in-band status nibble

  assign spd = rgp_spd(SPEED);
  // reported between frames: link, speed as clock rate, duplex
  assign status = {IBS_DUPLEX, spd, IBS_LINK};

  // transmit lane, clock made here at the speed rate
  rgp_lane_tx u_send (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .speed    (spd),
    .dly_en   (1'b0),
    .byte_in  (SEND_BYTE),
    .valid_in (SEND_VALID),
    .err_in   (SEND_ERROR),
    .idle_in  (status),
    .ready    (SEND_READY),
    .lclk     (link.tx_clk),
    .lctl     (link.tx_ctl),
    .ld       (link.txd)
  );

  // receive lane, clock comes from the device
  rgp_lane_rx u_recv (
    .clk        (SYS_CLK),
    .rst        (RESET),
    .speed      (spd),
    .dly_en     (1'b0),
    .lclk       (link.rx_clk),
    .lctl       (link.rx_ctl),
    .ld         (link.rxd),
    .byte_out   (RECV_BYTE),
    .valid_out  (RECV_VALID),
    .err_out    (RECV_ERROR),
    .active_out (RECV_ACTIVE),
    .idle_out   ()
  );
endmodule

// [verif/rgp_checker.sv]
// link wire checks between the device end and the partner end
`timescale 1ns/10ps
module rgp_checker
  import rgp_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  input wire logic [1:0] SPEED,
  input wire logic       tx_clk,
  input wire logic       tx_ctl,
  input wire logic [3:0] txd,
  input wire logic       rx_clk,
  input wire logic       rx_ctl,
  input wire logic [3:0] rxd
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  logic [7:0] age_q;  // cycles since speed moved
  logic [7:0] txh_q;  // cycles since transmit clock edge
  logic [7:0] rxh_q;  // cycles since receive clock edge
  logic [7:0] half;   // half period for the speed
  logic       calm;   // speed settled long enough
  logic       slow;   // settled at 10 or 100
  assign half = SPEED == 2'b10 ? 8'h02 : SPEED == 2'b01 ? 8'h0A : 8'h64;
  assign calm = age_q == 8'hFF;
  assign slow = calm && SPEED != 2'b10;
  // ages restart on a speed move: the half in flight may be odd
  always_ff @(posedge SYS_CLK)
    if (RESET || $changed(SPEED)) age_q <= 8'h00;
    else if (!calm) age_q <= age_q + 8'h01;
  // length of the current transmit clock half
  always_ff @(posedge SYS_CLK)
    if (RESET || $changed(tx_clk)) txh_q <= 8'h00;
    else if (txh_q != 8'hFF) txh_q <= txh_q + 8'h01;
  // length of the current receive clock half
  always_ff @(posedge SYS_CLK)
    if (RESET || $changed(rx_clk)) rxh_q <= 8'h00;
    else if (rxh_q != 8'hFF) rxh_q <= rxh_q + 8'h01;
  chk_txd_on_edge: assert property ($changed(txd) |-> $changed(tx_clk))
    else $error("tx nibble moved off a clock edge");
  chk_txctl_on_edge: assert property ($changed(tx_ctl) |-> $changed(tx_clk))
    else $error("tx control moved off a clock edge");
  // egress delay lets data lead its clock by one cycle
  chk_rxd_near_edge: assert property ($changed(rxd) |-> ##[0:1] $changed(rx_clk))
    else $error("rx nibble moved away from a clock edge");
  chk_rxctl_near_edge: assert property ($changed(rx_ctl) |-> ##[0:1] $changed(rx_clk))
    else $error("rx control moved away from a clock edge");
  chk_tx_half_len: assert property (calm && $changed(tx_clk) |-> txh_q == half - 8'h01)
    else $error("tx clock half period wrong");
  chk_rx_half_len: assert property (calm && $changed(rx_clk) |-> rxh_q == half - 8'h01)
    else $error("rx clock half period wrong");
  chk_tx_slow_repeat: assert property (slow && $fell(tx_clk) |-> $stable(txd))
    else $error("slow tx nibble not repeated");
  chk_rx_slow_repeat: assert property (slow && $fell(rx_clk) |-> $stable(rxd))
    else $error("slow rx nibble not repeated");
  cover property ($rose(tx_ctl));
  cover property (slow && $rose(rx_ctl));
  cover property (calm && SPEED == 2'b10 && $fell(rx_ctl));
endmodule

// [verif/tb.sv]
// self-checking bench: both ends joined, registers and traffic exercised
`timescale 1ns/10ps
module tb;
  import rgp_pkg::*;
  logic       clk, rst, wr, rd;       // clock, reset, strobes
  logic [7:0] addr, wdata, rdata;     // register port
  logic [1:0] p_spd, spd;             // partner speed, device speed
  logic       ibs_link, ibs_dup;      // partner in-band status
  logic [7:0] d_sb, p_sb, d_rb, p_rb; // bytes each way
  logic       d_sv, d_se, d_sr, d_rv, d_re, d_ra;
  logic       p_sv, p_se, p_sr, p_rv, p_re, p_ra;
  logic       en, lnk_up, fdx;        // device status outputs
  logic [8:0] dq[$], pq[$];           // error and byte received
  int         fail_count, samples_checked;
  rgp_if lnk();
  rgp_device u_rgp_device (.SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MODE_STRAP(2'b11), .SPEED_STRAP(1'b1),
    .INBAND_STATUS_STRAP_PIN(1'b1), .SEND_BYTE(d_sb), .SEND_VALID(d_sv), .SEND_ERROR(d_se),
    .SEND_READY(d_sr), .RECV_BYTE(d_rb), .RECV_VALID(d_rv), .RECV_ERROR(d_re), .RECV_ACTIVE(d_ra),
    .PORT_ENABLED(en), .LINK_UP(lnk_up), .SPEED(spd), .FULL_DUPLEX(fdx), .link(lnk.device));
  rgp_partner u_rgp_partner (.SYS_CLK(clk), .RESET(rst), .SPEED(p_spd), .IBS_LINK(ibs_link),
    .IBS_DUPLEX(ibs_dup), .SEND_BYTE(p_sb), .SEND_VALID(p_sv), .SEND_ERROR(p_se),
    .SEND_READY(p_sr), .RECV_BYTE(p_rb), .RECV_VALID(p_rv), .RECV_ERROR(p_re), .RECV_ACTIVE(p_ra),
    .link(lnk.partner));
  rgp_checker u_rgp_checker (.SYS_CLK(clk), .RESET(rst), .SPEED(p_spd), .tx_clk(lnk.tx_clk),
    .tx_ctl(lnk.tx_ctl), .txd(lnk.txd), .rx_clk(lnk.rx_clk), .rx_ctl(lnk.rx_ctl), .rxd(lnk.rxd));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // collect what each end hands up
  always @(posedge clk)
  begin
    if (d_rv === 1'b1) dq.push_back({d_re, d_rb});
    if (p_rv === 1'b1) pq.push_back({p_re, p_rb});
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({1'b0, rdata}, {1'b0, exp});
  endtask
  // n bytes each way at once, error on the last, each held until its slot
  task automatic frame(input int n, input logic [7:0] b0);
    dq.delete();
    pq.delete();
    @(posedge clk);
    fork
      begin
        for (int i = 0; i < n; i++)
        begin
          p_sb <= b0 ^ 8'(i);
          p_se <= i == n - 1;
          p_sv <= 1'b1;
          do @(negedge clk); while (p_sr !== 1'b1);
          @(posedge clk);
        end
        p_sv <= 1'b0;
      end
      begin
        for (int i = 0; i < n; i++)
        begin
          d_sb <= ~(b0 ^ 8'(i));
          d_se <= i == n - 1;
          d_sv <= 1'b1;
          do @(negedge clk); while (d_sr !== 1'b1);
          @(posedge clk);
        end
        d_sv <= 1'b0;
      end
    join
    repeat (3000) if (dq.size() < n || pq.size() < n) @(posedge clk);
    chk(9'(dq.size() + pq.size()), 9'(2 * n));
    for (int i = 0; i < n; i++)
    begin
      chk(dq[i], {i == n - 1, b0 ^ 8'(i)});
      chk(pq[i], {i == n - 1, ~(b0 ^ 8'(i))});
    end
    // a slow link needs a whole half period before control is seen low again
    repeat (250) @(posedge clk);
    chk({7'h00, d_ra, p_ra}, 9'h000);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run is a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end
  initial
  begin
    {rst, wr, rd, addr, wdata} = {1'b1, 18'h0};
    {p_sv, p_se, p_sb, d_sv, d_se, d_sb} = 20'h0;
    {p_spd, ibs_dup} = 3'b101;
    ibs_link = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    rd_reg(8'h00, 8'h50);
    rd_reg(8'h01, 8'h4C);
    rd_reg(8'h03, 8'h8D);
    rd_reg(8'h02, 8'h00);
    chk({4'h0, en, lnk_up, fdx, spd}, 9'h01E);
    frame(4, 8'h3C);
    // partner falls to 100 half duplex, device follows in-band
    p_spd <= 2'b01;
    ibs_dup <= 1'b0;
    repeat (400) if (spd !== 2'b01 || fdx !== 1'b0) @(posedge clk);
    rd_reg(8'h03, 8'h83);
    chk({4'h0, en, lnk_up, fdx, spd}, 9'h019);
    frame(3, 8'hC5);
    wr_reg(8'h01, 8'hFF);
    rd_reg(8'h01, 8'h5C);
    wr_reg(8'h01, 8'h18);
    rd_reg(8'h01, 8'h18);
    chk({4'h0, en, lnk_up, fdx, spd}, 9'h01D);
    wr_reg(8'h00, 8'hFF);
    rd_reg(8'h00, 8'h50);
    wr_reg(8'h00, 8'h00);
    p_spd <= 2'b00;
    rd_reg(8'h00, 8'h00);
    chk({4'h0, en, lnk_up, fdx, spd}, 9'h018);
    frame(2, 8'h96);
    stop_test;
  end
endmodule
